/* verilog/ssbr_shift_store.sv */
`timescale 1ns/10ps

module ssbr_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 32
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] ONE_COUNT = CW'(1);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic full_q;
    logic empty_q;
    logic push;
    logic pop;

    assign push = in_valid_i & ~full_q;
    assign pop = out_ready_i & ~empty_q;
    assign in_ready_o = ~full_q;
    assign out_valid_o = ~empty_q;
    assign out_data_o = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + ONE_COUNT;
        end else if (pop && !push) begin
            count_d = count_q - ONE_COUNT;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + AW'(1);
            end
        end
    end

    // flags are registered so full and empty never glitch on the ports
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_q <= '0;
            full_q <= 1'h0;
            empty_q <= 1'h1;
        end else begin
            count_q <= count_d;
            full_q <= (count_d == FULL_COUNT);
            empty_q <= (count_d == '0);
        end
    end

endmodule : ssbr_fifo

// Contract
// [RQ1] The block holds eight shift stages, each with its own storage latch driving tri-state outputs.
// [RQ2] Each rising shift clock edge loads serial data into stage one and moves the rest toward stage eight; the code drops a rise at a full queue.
// [RQ3] Latches follow the stages while strobe is high and hold, with outputs steady, while it is low.
// [RQ4] With output enable high the outputs show the latches, with it low they all float.
// [RQ5] Each rising edge moves stage seven into stage eight and shows that bit on the rising serial output; the code drops a rise at a full queue.
// [RQ6] The same bit appears on a second serial output at the following falling shift clock edge.
// [RQ7] The host chains the rising output for fast edges and the falling output for slow ones.
// [RQ8] Shifting and both serial outputs run whatever the output enable; it gates only the bus.
module ssbr_shift_store
    import ssbr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic shift_clock_i,
    input wire logic serial_data_i,
    input wire logic strobe_i,
    input wire logic output_enable_i,
    input wire logic shift_hold_i,
    output logic serial_ready_o,
    output ssbr_bus_s bus_o,
    output logic serial_out_rising_o,
    output logic serial_out_falling_o
);
    logic shift_clock_q;
    logic clk_rise;
    logic clk_fall;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [SSBR_FIFO_WIDTH-1:0] fifo_out_data;
    logic shift_step;
    logic [SSBR_STAGES-1:0] stage_q;
    logic [SSBR_STAGES-1:0] latch_q;
    logic serial_ready_q;
    logic serial_out_rising_q;
    logic serial_out_falling_q;
    ssbr_bus_s bus_q;

    // shift clock is slow host logic, sampled on the core clock
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_clock_q <= 1'h0;
        end else begin
            shift_clock_q <= shift_clock_i;
        end
    end

    assign clk_rise = shift_clock_i & ~shift_clock_q;
    assign clk_fall = ~shift_clock_i & shift_clock_q;

    // bits captured at each rising edge queue here; a hold drains nothing so
    // the host sees ready fall and must pause its clock
    ssbr_fifo #(
        .WIDTH(SSBR_FIFO_WIDTH),
        .DEPTH(SSBR_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(clk_rise),
        .in_ready_o(fifo_in_ready),
        .in_data_i(serial_data_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // a bit refused at a full queue is lost for good; the host must watch ready
    assign fifo_out_ready = ~shift_hold_i;
    assign shift_step = fifo_out_valid & fifo_out_ready;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_ready_q <= 1'h0;
        end else begin
            serial_ready_q <= fifo_in_ready;
        end
    end

    // shift chain, one flop per stage
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_q[0] <= SSBR_STAGE_RESET[0];
        end else if (shift_step) begin
            stage_q[0] <= fifo_out_data[0]; // [RQ2]
        end
    end

    for (genvar i = 1; i < SSBR_STAGES; i++) begin : g_stage
        always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                stage_q[i] <= SSBR_STAGE_RESET[i];
            end else if (shift_step) begin
                stage_q[i] <= stage_q[i-1]; // [RQ1] [RQ2] [RQ8]
            end
        end
    end

    // transparent while strobe is high; one core cycle behind the stages
    // strobe is sampled, so a pulse shorter than one core cycle can be missed
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latch_q <= SSBR_LATCH_RESET;
        end else if (strobe_i) begin
            latch_q <= stage_q; // [RQ3]
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_q <= '0;
        end else begin
            // enables kept per pin so each bus line can be resolved on its own
            bus_q.data <= latch_q; // [RQ1]
            bus_q.oe <= {SSBR_STAGES{output_enable_i}}; // [RQ4] [RQ8]
        end
    end

    // rising output takes the bit entering stage eight in the same step
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_out_rising_q <= SSBR_SERIAL_RESET;
        end else if (shift_step) begin
            serial_out_rising_q <= stage_q[SSBR_STAGES-2]; // [RQ5]
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_out_falling_q <= SSBR_SERIAL_RESET;
        // a stalled chain makes the falling copy repeat the old bit, never run ahead
        end else if (clk_fall) begin
            serial_out_falling_q <= serial_out_rising_q; // [RQ6]
        end
    end

    assign serial_ready_o = serial_ready_q;
    assign bus_o = bus_q;
    assign serial_out_rising_o = serial_out_rising_q;
    assign serial_out_falling_o = serial_out_falling_q;

endmodule : ssbr_shift_store

/* include/ssbr_pkg.sv */
package ssbr_pkg;

    localparam int unsigned SSBR_STAGES = 8;
    localparam int unsigned SSBR_FIFO_DEPTH = 32;
    localparam int unsigned SSBR_FIFO_WIDTH = 1;
    localparam logic [SSBR_STAGES-1:0] SSBR_STAGE_RESET = 8'h00;
    localparam logic [SSBR_STAGES-1:0] SSBR_LATCH_RESET = 8'h00;
    localparam logic SSBR_SERIAL_RESET = 1'h0;

    typedef struct packed {
        logic [SSBR_STAGES-1:0] data;
        logic [SSBR_STAGES-1:0] oe;
    } ssbr_bus_s;

endpackage : ssbr_pkg

/* bench/ssbr_shift_store_checker.sv */
`timescale 1ns/10ps
module ssbr_shift_store_checker
    import ssbr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic strobe_i,
    input wire logic output_enable_i,
    input wire logic shift_hold_i,
    input wire logic serial_ready_o,
    input wire ssbr_bus_s bus_o,
    input wire logic serial_out_rising_o,
    input wire logic serial_out_falling_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    chk_oe_all_eight: assert property (bus_o.oe == {8{bus_o.oe[0]}})
        else $error("enables differ");
    chk_shift_one_place: assert property ($changed(bus_o.data) && $past(strobe_i, 2)
        && $past(strobe_i, 3) |-> bus_o.data[7:1] == $past(bus_o.data[6:0])) else $error("bad shift");
    chk_drain_ready: assert property (!shift_hold_i [*3] |-> serial_ready_o)
        else $error("ready low");
    chk_latch_hold: assert property (!$past(strobe_i, 2) |-> $stable(bus_o.data))
        else $error("bus moved");
    chk_oe_follow: assert property (bus_o.oe == {8{$past(output_enable_i)}})
        else $error("oe lag");
    chk_last_stage: assert property ($past(strobe_i, 2) |->
        bus_o.data[7] == $past(serial_out_rising_o, 2)) else $error("stage8 mismatch");
    chk_fall_copy: assert property ($changed(serial_out_falling_o) |->
        serial_out_falling_o == $past(serial_out_rising_o)) else $error("fall copy");
endmodule : ssbr_shift_store_checker
bind ssbr_shift_store ssbr_shift_store_checker u_chk (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .strobe_i(strobe_i), .output_enable_i(output_enable_i),
    .shift_hold_i(shift_hold_i), .serial_ready_o(serial_ready_o), .bus_o(bus_o),
    .serial_out_rising_o(serial_out_rising_o), .serial_out_falling_o(serial_out_falling_o));

/* bench/ssbr_host_model.sv */
`timescale 1ns/10ps
module ssbr_host_model (
    input wire logic core_clk_i,
    output logic shift_clock_o,
    output logic serial_data_o
);
    initial shift_clock_o = 1'h0;
    initial serial_data_o = 1'h0;
    // fast edges here, so a chain would take the rising output
    task automatic send(input logic b);
        @(posedge core_clk_i);
        shift_clock_o <= 1'h1;
        serial_data_o <= b;
        repeat (3) @(posedge core_clk_i);
        shift_clock_o <= 1'h0;
        // data is stale once taken, so show its inverse
        serial_data_o <= ~b;
    endtask : send
endmodule : ssbr_host_model

/* bench/ssbr_shift_store_tb.sv */
`timescale 1ns/10ps
module ssbr_shift_store_tb
    import ssbr_pkg::*;
();
    logic core_clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic strobe = 1'h1;
    logic oe = 1'h0;
    logic hold = 1'h0;
    logic ready, sro, sfo, sclk, sdat;
    ssbr_bus_s bus;
    wire [7:0] pin;
    logic [7:0] lfsr = 8'h2E;
    logic [7:0] exp_q = 8'h00;
    logic [7:0] held;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    for (genvar i = 0; i < 8; i++) assign pin[i] = bus.oe[i] ? bus.data[i] : 1'hZ;
    initial forever #2.5 core_clk_i = ~core_clk_i;
    ssbr_host_model u_host (.core_clk_i(core_clk_i), .shift_clock_o(sclk), .serial_data_o(sdat));
    ssbr_shift_store u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .shift_clock_i(sclk), .serial_data_i(sdat), .strobe_i(strobe),
        .output_enable_i(oe), .shift_hold_i(hold), .serial_ready_o(ready),
        .bus_o(bus), .serial_out_rising_o(sro), .serial_out_falling_o(sfo));
    function automatic logic [7:0] step(input logic [7:0] l);
        return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
    endfunction : step
    function automatic logic [7:0] want(input logic [7:0] d, input logic e);
        return e ? d : 8'hZZ;
    endfunction : want
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic shift_in(input logic keep);
        lfsr = step(lfsr);
        u_host.send(lfsr[0]);
        if (keep) exp_q = {exp_q[6:0], lfsr[0]};
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask : shift_in
    task automatic close_out();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1'h1;
        @(posedge core_clk_i);
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk_i);
            oe <= lfsr[1] | (i < 9);
            shift_in(1'h1);
            check(pin, want(exp_q, oe));
            check({7'h00, sro}, {7'h00, exp_q[7]});
            check({7'h00, sfo}, {7'h00, exp_q[7]});
        end
        @(posedge core_clk_i);
        oe <= 1'h1;
        strobe <= 1'h0;
        held = exp_q;
        for (int i = 0; i < 3; i++) shift_in(1'h1);
        check(pin, held);
        @(posedge core_clk_i);
        strobe <= 1'h1;
        hold <= 1'h1;
        // one rise past a full queue is dropped
        for (int i = 0; i < 33; i++) shift_in(i < 32);
        check({7'h00, ready}, 8'h00);
        @(posedge core_clk_i);
        hold <= 1'h0;
        repeat (40) @(posedge core_clk_i);
        #1;
        check(pin, exp_q);
        check({7'h00, ready}, 8'h01);
        close_out();
    end
endmodule : ssbr_shift_store_tb
